// ==== rtl/cmb_can_buffers.sv ====
// Receive FIFO, transmit buffers and scheduling of the CAN controller
`timescale 1ns/1ps
module cmb_can_buffers (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      rxValid,
  output wire logic                      rxReady,
  input  wire logic [cmb_pkg::BYTE_W-1:0] rxByte,
  input  wire logic                      rxLast,
  input  wire logic                      rxGood,
  input  wire logic                      txActive,
  input  wire logic                      loopBack,
  output wire logic                      ackEnable,
  input  wire logic [1:0]                filterMode,
  input  wire logic [cmb_pkg::ID_W-1:0]  acceptancePatternBytes,
  input  wire logic [cmb_pkg::ID_W-1:0]  acceptanceMaskBytes,
  input  wire logic                      receiveFullClr,
  input  wire logic                      rxIe,
  input  wire logic                      overrunClr,
  input  wire logic                      overrunIe,
  input  wire logic [cmb_pkg::IDX_W-1:0] fgAddr,
  output logic      [cmb_pkg::BYTE_W-1:0] fgData,
  output wire logic                      receiveFullFlag,
  output wire logic                      filterHitBitHigh,
  output wire logic                      filterHitBitLow,
  output wire logic                      overrun,
  output wire logic                      rxIrq,
  output wire logic                      errIrq,
  input  wire logic                      txWrEn,
  input  wire logic                      rankWrEn,
  input  wire logic [cmb_pkg::SEL_W-1:0] txWrBuf,
  input  wire logic [cmb_pkg::IDX_W-1:0] txWrAddr,
  input  wire logic [cmb_pkg::BYTE_W-1:0] txWrData,
  input  wire logic [cmb_pkg::NUM_TX-1:0] transmitEmptyClr,
  input  wire logic [cmb_pkg::NUM_TX-1:0] abortRequestSet,
  input  wire logic [cmb_pkg::NUM_TX-1:0] txIe,
  output wire logic [cmb_pkg::NUM_TX-1:0] transmitEmptyFlag,
  output wire logic [cmb_pkg::NUM_TX-1:0] abortRequestBit,
  output wire logic [cmb_pkg::NUM_TX-1:0] abortAcknowledgeBit,
  output wire logic                      txIrq,
  input  wire logic                      arbStart,
  input  wire logic                      txDone,
  input  wire logic                      txFail,
  input  wire logic [cmb_pkg::IDX_W-1:0] txRdAddr,
  output wire logic                      txPending,
  output wire logic [cmb_pkg::SEL_W-1:0] txSel,
  output logic      [cmb_pkg::BYTE_W-1:0] txRdData
);
  localparam int NB = cmb_pkg::BUF_BYTES;
  localparam int NT = cmb_pkg::NUM_TX;
  localparam int BW = cmb_pkg::BYTE_W;

  // Receive storage
  logic [BW-1:0]              rxBackgroundBuffer [NB];
  logic [BW-1:0]              rxForegroundBuffer [NB];
  logic [BW-1:0]              idCap_r [cmb_pkg::ID_BYTES];
  logic [cmb_pkg::IDX_W-1:0]  byteIdx_r;
  logic                       commit_r;
  logic                       commitGood_r;
  logic                       commitOwn_r;
  logic                       rxFull_r;
  logic                       bgHeld_r;
  logic [1:0]                 hitBg_r;
  logic [1:0]                 fgHit_r;
  logic                       overrun_r;

  wire                        fifoValid;
  wire [cmb_pkg::WORD_W-1:0]  fifoData;
  // Drain stalls one cycle per frame end so the filter sees a stable identifier
  wire                        fifoReady = !commit_r;
  wire                        pop       = fifoValid && fifoReady;
  wire                        popLast   = pop && fifoData[cmb_pkg::WORD_LAST];
  wire                        inBuf     = (byteIdx_r <= cmb_pkg::LAST_IDX);
  wire                        storeBg   = pop && inBuf && !bgHeld_r;
  wire                        storeId   = pop && (byteIdx_r < cmb_pkg::ID_END);

  cmb_fifo #(
    .WIDTH (cmb_pkg::WORD_W),
    .DEPTH (cmb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .inData   ({rxGood, rxLast, rxByte}),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData)
  );

  wire                        fHit;
  wire [1:0]                  fHitIdx;
  cmb_filter u_filter (
    .idBytes                ({idCap_r[0], idCap_r[1], idCap_r[2], idCap_r[3]}),
    .acceptancePatternBytes (acceptancePatternBytes),
    .acceptanceMaskBytes    (acceptanceMaskBytes),
    .filterMode             (filterMode),
    .hit                    (fHit),
    .hitIdx                 (fHitIdx)
  );

  // Own frames outside loop-back are never accepted
  wire accept     = commit_r && commitGood_r && !commitOwn_r && fHit;
  wire copyDirect = accept && !bgHeld_r && !rxFull_r;
  wire copyHeld   = bgHeld_r && !rxFull_r;
  wire copyFg     = copyDirect || copyHeld;
  wire holdBg     = accept && !bgHeld_r && rxFull_r;
  wire overrunEv  = accept && bgHeld_r;

  assign ackEnable        = !(txActive && !loopBack);
  assign receiveFullFlag  = rxFull_r;
  assign filterHitBitHigh = fgHit_r[1];
  assign filterHitBitLow  = fgHit_r[0];
  assign overrun          = overrun_r;
  assign rxIrq            = rxFull_r && rxIe;
  assign errIrq           = overrun_r && overrunIe;

  always_ff @(posedge clk) begin
    if (storeBg) rxBackgroundBuffer[byteIdx_r] <= fifoData[BW-1:0];
    if (storeId) idCap_r[byteIdx_r[1:0]] <= fifoData[BW-1:0];
  end

  always_ff @(posedge clk) begin
    if (copyFg) rxForegroundBuffer <= rxBackgroundBuffer;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      byteIdx_r    <= '0;
      commit_r     <= 1'b0;
      commitGood_r <= 1'b0;
      commitOwn_r  <= 1'b0;
    end else begin
      commit_r <= popLast;
      if (popLast) begin
        byteIdx_r    <= '0;
        commitGood_r <= fifoData[cmb_pkg::WORD_GOOD];
        commitOwn_r  <= txActive && !loopBack;
      end else if (pop && inBuf) begin
        byteIdx_r <= byteIdx_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxFull_r  <= 1'b0;
      bgHeld_r  <= 1'b0;
      hitBg_r   <= 2'h0;
      fgHit_r   <= 2'h0;
      overrun_r <= 1'b0;
    end else begin
      // Copy needs receive full clear; a copy wins over a same-cycle clear
      if (copyFg) rxFull_r <= 1'b1;
      else if (receiveFullClr) rxFull_r <= 1'b0;
      if (holdBg) bgHeld_r <= 1'b1;
      else if (copyHeld) bgHeld_r <= 1'b0;
      if (holdBg) hitBg_r <= fHitIdx;
      if (copyFg) fgHit_r <= copyHeld ? hitBg_r : fHitIdx;
      if (overrunEv) overrun_r <= 1'b1;
      else if (overrunClr) overrun_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) fgData <= '0;
    else if (fgAddr <= cmb_pkg::LAST_IDX) fgData <= rxForegroundBuffer[fgAddr];
    else fgData <= '0;
  end

  // Transmit storage
  logic [BW-1:0]             txBuf [NT][NB];
  logic [BW-1:0]             localPriorityField [NT];
  logic [NT-1:0]             txEmpty_r;
  logic [NT-1:0]             abortReq_r;
  logic [NT-1:0]             abortAck_r;
  logic [cmb_pkg::SEL_W-1:0] txSel_r;
  logic                      onBus_r;
  logic [cmb_pkg::SEL_W-1:0] best;
  logic                      anyPending;

  wire [NT-1:0] pending = ~txEmpty_r;
  wire          wrOk    = (txWrBuf < cmb_pkg::SEL_W'(NT)) && txEmpty_r[txWrBuf];

  // Lowest value wins; ties go to the lower buffer number
  always_comb begin
    best       = '0;
    anyPending = 1'b0;
    for (int i = 0; i < NT; i++) begin
      if (pending[i] && (!anyPending || localPriorityField[i] < localPriorityField[best])) begin
        best       = cmb_pkg::SEL_W'(i);
        anyPending = 1'b1;
      end
    end
  end

  logic [NT-1:0] abortGo;
  logic [NT-1:0] doneHit;
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      abortGo[i] = abortReq_r[i] && pending[i] && !(onBus_r && txSel_r == cmb_pkg::SEL_W'(i));
      doneHit[i] = txDone && onBus_r && txSel_r == cmb_pkg::SEL_W'(i);
    end
  end

  assign transmitEmptyFlag   = txEmpty_r;
  assign abortRequestBit     = abortReq_r;
  assign abortAcknowledgeBit = abortAck_r;
  assign txIrq               = |(txEmpty_r & txIe);
  assign txPending           = anyPending;
  assign txSel               = txSel_r;

  always_ff @(posedge clk) begin
    if (txWrEn && wrOk && txWrAddr <= cmb_pkg::LAST_IDX) txBuf[txWrBuf][txWrAddr] <= txWrData;
    if (rankWrEn && wrOk) localPriorityField[txWrBuf] <= txWrData;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txEmpty_r  <= cmb_pkg::EMPTY_RESET;
      abortReq_r <= '0;
      abortAck_r <= '0;
      txSel_r    <= '0;
      onBus_r    <= 1'b0;
    end else begin
      // Setting the empty flag wins over a same-cycle clear
      txEmpty_r  <= (txEmpty_r & ~transmitEmptyClr) | doneHit | abortGo;
      abortAck_r <= (abortAck_r & ~(transmitEmptyClr & txEmpty_r) & ~doneHit) | abortGo;
      abortReq_r <= (abortReq_r | (abortRequestSet & pending)) & ~doneHit & ~abortGo;
      if (arbStart && anyPending) begin
        txSel_r <= best;
        onBus_r <= 1'b1;
      end else if (txDone || txFail) begin
        onBus_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) txRdData <= '0;
    else if (txRdAddr <= cmb_pkg::LAST_IDX) txRdData <= txBuf[txSel_r][txRdAddr];
    else txRdData <= '0;
  end
endmodule // cmb_can_buffers

// ==== shared/cmb_pkg.sv ====
// Constants shared by the CAN message buffer and acceptance filter block
// Operation
// - Two-deep receive FIFO, hidden and visible buffer
// - Receive buffers hold thirteen bytes each
// - Receive full only for accepted good frames
// - Background written during reception, filtered in parallel
// - Accepted frame copied when receive full clear
// - Own frames stay in background unless loop-back
// - Lost arbitration continues as normal receiver
// - Both buffers full: discard, flag overrun
// - Three transmit buffers plus priority bytes
// - Successful send sets empty flag, interrupt
// - Lowest priority value transmits first
// - Reselect buffer at every arbitration attempt
// - Abort unless on bus; acknowledge shows outcome
// - Pattern compared, mask bits are don't care
// - Two-bit hit index, lowest filter wins
// - Single mode: one 32-bit filter
// - Dual mode: two 16-bit filters
// - Quad mode: four 8-bit filters
// - Closed mode never fills foreground buffer
// - Write one clears flag; set wins
// - Interrupt pending while any flag set; code also needs that flag's enable, and abort acknowledge raises none
package cmb_pkg;
  localparam int BUF_BYTES = 13;
  localparam int IDX_W     = 4;
  localparam int BYTE_W    = 8;
  localparam int ID_W      = 32;
  localparam int HALF_W    = 16;
  localparam int NUM_TX    = 3;
  localparam int SEL_W     = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W    = 10;
  localparam int WORD_LAST = 8;
  localparam int WORD_GOOD = 9;
  localparam int ID_BYTES  = 4;
  localparam logic [NUM_TX-1:0] EMPTY_RESET = 3'h7;
  localparam logic [IDX_W-1:0] LAST_IDX  = 4'hC;
  localparam logic [IDX_W-1:0] ID_END    = 4'h4;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL   = 2'h1;
  localparam logic [1:0] MODE_QUAD   = 2'h2;
  localparam logic [1:0] MODE_CLOSED = 2'h3;
endpackage

// ==== rtl/cmb_fifo.sv ====
// Parameterised valid/ready FIFO for the receive byte stream
`timescale 1ns/1ps
module cmb_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output wire logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output wire logic             outValid,
  input  wire logic             outReady,
  output wire logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0]   wrPtr_r;
  logic [PTR_W:0]   rdPtr_r;
  wire              full  = (wrPtr_r[PTR_W] != rdPtr_r[PTR_W]) && (wrPtr_r[PTR_W-1:0] == rdPtr_r[PTR_W-1:0]);
  wire              empty = (wrPtr_r == rdPtr_r);
  wire              push  = inValid && !full;
  wire              pop   = outReady && !empty;
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_r[PTR_W-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r[PTR_W-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule // cmb_fifo

// ==== rtl/cmb_filter.sv ====
// Maskable identifier acceptance filter bank
`timescale 1ns/1ps
module cmb_filter (
  input  wire logic [cmb_pkg::ID_W-1:0] idBytes,
  input  wire logic [cmb_pkg::ID_W-1:0] acceptancePatternBytes,
  input  wire logic [cmb_pkg::ID_W-1:0] acceptanceMaskBytes,
  input  wire logic [1:0]               filterMode,
  output wire logic                     hit,
  output wire logic [1:0]               hitIdx
);
  localparam int B = cmb_pkg::BYTE_W;
  localparam int H = cmb_pkg::HALF_W;
  localparam int W = cmb_pkg::ID_W;
  // Bit matches where equal or masked
  wire [W-1:0] eqFull = ~(idBytes ^ acceptancePatternBytes) | acceptanceMaskBytes;
  wire [H-1:0] eqHalf1 = ~(idBytes[W-1 -: H] ^ acceptancePatternBytes[H-1:0]) | acceptanceMaskBytes[H-1:0];
  wire [B-1:0] eqQ1 = ~(idBytes[W-1 -: B] ^ acceptancePatternBytes[W-B-1 -: B]) | acceptanceMaskBytes[W-B-1 -: B];
  wire [B-1:0] eqQ2 = ~(idBytes[W-1 -: B] ^ acceptancePatternBytes[H-1 -: B]) | acceptanceMaskBytes[H-1 -: B];
  wire [B-1:0] eqQ3 = ~(idBytes[W-1 -: B] ^ acceptancePatternBytes[B-1:0]) | acceptanceMaskBytes[B-1:0];
  wire single = (filterMode == cmb_pkg::MODE_SINGLE);
  wire dual   = (filterMode == cmb_pkg::MODE_DUAL);
  wire quad   = (filterMode == cmb_pkg::MODE_QUAD);
  wire f0 = (single && (&eqFull)) || (dual && (&eqFull[W-1 -: H])) || (quad && (&eqFull[W-1 -: B]));
  wire f1 = (dual && (&eqHalf1)) || (quad && (&eqQ1));
  wire f2 = quad && (&eqQ2);
  wire f3 = quad && (&eqQ3);
  // Closed mode leaves every section false
  assign hit    = f0 || f1 || f2 || f3;
  assign hitIdx = f0 ? 2'h0 : f1 ? 2'h1 : f2 ? 2'h2 : 2'h3;
endmodule // cmb_filter

// ==== bench/cmb_can_buffers_chk.sv ====
// Port-level checker of flag and interrupt relations
`timescale 1ns/1ps
module cmb_can_buffers_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       txActive,
  input wire logic       loopBack,
  input wire logic       ackEnable,
  input wire logic       receiveFullClr,
  input wire logic       rxIe,
  input wire logic       overrunClr,
  input wire logic       overrunIe,
  input wire logic       receiveFullFlag,
  input wire logic       overrun,
  input wire logic       rxIrq,
  input wire logic       errIrq,
  input wire logic [2:0] txIe,
  input wire logic [2:0] transmitEmptyClr,
  input wire logic [2:0] transmitEmptyFlag,
  input wire logic [2:0] abortAcknowledgeBit,
  input wire logic       txIrq,
  input wire logic       txDone,
  input wire logic [1:0] txSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rx_irq_gate: assert property (rxIrq == (receiveFullFlag & rxIe))
    else $error("receive interrupt does not follow its flag");
  a_err_irq_gate: assert property (errIrq == (overrun & overrunIe))
    else $error("error interrupt does not follow overrun");
  a_tx_irq_gate: assert property (txIrq == |(transmitEmptyFlag & txIe))
    else $error("transmit interrupt does not follow empty flags");
  a_own_no_ack: assert property (ackEnable == !(txActive && !loopBack))
    else $error("acknowledge enable wrong for own frame");
  a_done_sets_empty: assert property (txDone |=> transmitEmptyFlag[$past(txSel)])
    else $error("sent buffer not marked empty");
  a_full_stands: assert property (receiveFullFlag && !receiveFullClr |=> receiveFullFlag)
    else $error("receive full dropped without clear");
  a_ovr_stands: assert property (overrun && !overrunClr |=> overrun)
    else $error("overrun dropped without clear");
  a_empty_stands: assert property (((($past(transmitEmptyFlag) & ~$past(transmitEmptyClr)) & ~transmitEmptyFlag) == 3'h0))
    else $error("empty flag dropped without clear");
  a_ack_has_empty: assert property ((abortAcknowledgeBit & ~transmitEmptyFlag) == 3'h0)
    else $error("abort acknowledge on a busy buffer");
endmodule // cmb_can_buffers_chk
bind cmb_can_buffers cmb_can_buffers_chk chk (.*);

// ==== bench/cmb_engine_model.sv ====
// Protocol engine model: streams one 13-byte frame per request
`timescale 1ns/1ps
module cmb_engine_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         sendRx,
  input  wire logic [103:0] frm,
  input  wire logic         frameGood,
  output wire logic         rxBusy,
  output wire logic         rxValid,
  input  wire logic         rxReady,
  output wire logic [7:0]   rxByte,
  output wire logic         rxLast,
  output wire logic         rxGood
);
  logic [3:0] idx_r;
  logic       act_r;
  logic [7:0] junk_r;
  // Idle lines churn so stale bytes never look valid
  assign rxValid = act_r;
  assign rxBusy  = act_r | sendRx;
  assign rxLast  = act_r ? idx_r == cmb_pkg::LAST_IDX : junk_r[0];
  assign rxGood  = rxLast & act_r ? frameGood : junk_r[1];
  assign rxByte  = act_r ? frm[8*(12-idx_r) +: 8] : junk_r;
  always_ff @(posedge clk) begin
    junk_r <= junk_r + 8'h35;
    if (rst) begin
      act_r  <= 1'h0;
      idx_r  <= 4'h0;
      junk_r <= 8'h00;
    end else if (!act_r) begin
      act_r <= sendRx;
      idx_r <= 4'h0;
    end else if (rxReady) begin
      idx_r <= idx_r + 4'h1;
      act_r <= idx_r != cmb_pkg::LAST_IDX;
    end
  end
endmodule // cmb_engine_model

// ==== bench/tb_cmb_can_buffers.sv ====
// Scenario bench for the CAN message buffer block
`timescale 1ns/1ps
module tb_cmb_can_buffers;
  logic clk, rst, sendRx, rxBusy, frameGood, rxValid, rxReady, rxLast, rxGood, txActive, loopBack;
  logic ackEnable, receiveFullClr, rxIe, overrunClr, overrunIe, receiveFullFlag, overrun, rxIrq, errIrq;
  logic filterHitBitHigh, filterHitBitLow, txWrEn, rankWrEn, arbStart, txDone, txFail, txPending, txIrq;
  logic [1:0]   filterMode, txWrBuf, txSel;
  logic [2:0]   transmitEmptyClr, abortRequestSet, txIe, transmitEmptyFlag, abortRequestBit, abortAcknowledgeBit;
  logic [3:0]   fgAddr, txWrAddr, txRdAddr;
  logic [7:0]   rxByte, fgData, txWrData, txRdData;
  logic [31:0]  acceptancePatternBytes, acceptanceMaskBytes;
  logic [103:0] frm;
  int           err_count, checked;
  cmb_can_buffers dut (.*);
  cmb_engine_model peer (.clk(clk), .rst(rst), .sendRx(sendRx), .frm(frm), .frameGood(frameGood),
    .rxBusy(rxBusy), .rxValid(rxValid), .rxReady(rxReady), .rxByte(rxByte), .rxLast(rxLast), .rxGood(rxGood));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic clr(input logic [2:0] te, input logic [2:0] ab, input logic rf);
    @(posedge clk);
    transmitEmptyClr <= te;
    abortRequestSet <= ab;
    receiveFullClr <= rf;
    overrunClr <= rf;
    @(posedge clk);
    {transmitEmptyClr, abortRequestSet, receiveFullClr, overrunClr} <= 8'h00;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  // Data bytes repeat the low identifier byte so copies are traceable
  task automatic rxFrame(input logic [1:0] m, input logic [31:0] p, input logic [31:0] k, input logic [31:0] id,
                     input logic g);
    @(posedge clk);
    {filterMode, acceptancePatternBytes, acceptanceMaskBytes} <= {m, p, k};
    frm <= {id, {9{id[7:0]}}};
    frameGood <= g;
    sendRx <= 1'h1;
    @(posedge clk);
    sendRx <= 1'h0;
    for (int n = 0; n < 40 && rxBusy; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rxc(input logic [1:0] m, input logic [31:0] p, input logic [31:0] k, input logic [31:0] id,
                     input logic g, input logic [2:0] e);
    rxFrame(m, p, k, id, g);
    chk({receiveFullFlag, filterHitBitHigh, filterHitBitLow}, e);
    clr(3'h0, 3'h0, 1'h1);
  endtask
  task automatic rd(input logic t, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    if (t) txRdAddr <= a;
    else fgAddr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(t ? txRdData : fgData, e);
  endtask
  task automatic txw(input logic [1:0] b, input logic p, input logic [7:0] d);
    @(posedge clk);
    {txWrBuf, txWrAddr, txWrData, txWrEn, rankWrEn} <= {b, 4'h0, d, !p, p};
    @(posedge clk);
    {txWrEn, rankWrEn} <= 2'h0;
  endtask
  task automatic eng(input int k);
    @(posedge clk);
    {arbStart, txDone, txFail} <= {k == 0, k == 1, k == 2};
    @(posedge clk);
    {arbStart, txDone, txFail} <= 3'h0;
    @(negedge clk);
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  initial begin
    {rst, rxIe, overrunIe, txIe} = 6'h3F;
    {sendRx, frameGood, txActive, loopBack, receiveFullClr, overrunClr, txWrEn, rankWrEn} = 8'h00;
    {arbStart, txDone, txFail, transmitEmptyClr, abortRequestSet, filterMode} = 11'h000;
    {fgAddr, txWrAddr, txRdAddr, txWrBuf, txWrData, acceptancePatternBytes, acceptanceMaskBytes} = '0;
    frm = '0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk({transmitEmptyFlag, receiveFullFlag, overrun, rxReady}, 6'h39);
    rxFrame(2'h0, 32'h1234_5678, 32'h0000_00FF, 32'h1234_56A1, 1'h1);
    chk({receiveFullFlag, rxIrq, filterHitBitHigh, filterHitBitLow}, 4'hC);
    rd(1'h0, 4'h2, 8'h56);
    rd(1'h0, 4'hC, 8'hA1);
    rd(1'h0, 4'hD, 8'h00);
    @(posedge clk);
    rxIe <= 1'h0;
    @(negedge clk);
    chk({receiveFullFlag, rxIrq}, 2'h2);
    @(posedge clk);
    rxIe <= 1'h1;
    rxFrame(2'h0, 32'h1234_5678, 32'h0000_00FF, 32'h1234_56B2, 1'h1);
    chk({receiveFullFlag, overrun}, 2'h2);
    rd(1'h0, 4'h4, 8'hA1);
    rxFrame(2'h0, 32'h1234_5678, 32'h0000_00FF, 32'h1234_56C3, 1'h1);
    chk({overrun, errIrq}, 2'h3);
    clr(3'h0, 3'h0, 1'h1);
    chk({receiveFullFlag, overrun}, 2'h2);
    rd(1'h0, 4'h4, 8'hB2);
    clr(3'h0, 3'h0, 1'h1);
    $display("test receive fifo done");
    rxc(2'h0, 32'h1234_5678, 32'h0000_0000, 32'h1334_5678, 1'h1, 3'h0);
    rxc(2'h0, 32'h1234_5678, 32'h0000_0000, 32'h1234_5678, 1'h0, 3'h0);
    rxc(2'h0, 32'h0000_0000, 32'hFFFF_FFFF, 32'h1234_5678, 1'h1, 3'h4);
    rxc(2'h1, 32'hFFFF_1234, 32'h0000_0000, 32'h1234_0000, 1'h1, 3'h5);
    rxc(2'h2, 32'h0000_1212, 32'h0000_0000, 32'h1234_0000, 1'h1, 3'h6);
    rxc(2'h3, 32'h1234_5678, 32'hFFFF_FFFF, 32'h1234_5678, 1'h1, 3'h2);
    $display("test filter modes done");
    @(posedge clk);
    txActive <= 1'h1;
    @(negedge clk);
    chk(ackEnable, 1'h0);
    rxc(2'h0, 32'h1234_5678, 32'h0000_0000, 32'h1234_5678, 1'h1, 3'h2);
    @(posedge clk);
    loopBack <= 1'h1;
    @(negedge clk);
    chk(ackEnable, 1'h1);
    rxc(2'h0, 32'h1234_5678, 32'h0000_0000, 32'h1234_5678, 1'h1, 3'h4);
    @(posedge clk);
    {txActive, loopBack} <= 2'h0;
    rxc(2'h0, 32'h1234_5678, 32'h0000_0000, 32'h1234_5678, 1'h1, 3'h4);
    $display("test own frames done");
    txw(2'h0, 1'h1, 8'h05);
    txw(2'h1, 1'h1, 8'h03);
    txw(2'h2, 1'h1, 8'h03);
    txw(2'h1, 1'h0, 8'h9C);
    clr(3'h7, 3'h0, 1'h0);
    chk({txPending, transmitEmptyFlag}, 4'h8);
    eng(0);
    chk(txSel, 2'h1);
    rd(1'h1, 4'h0, 8'h9C);
    eng(2);
    clr(3'h0, 3'h2, 1'h0);
    chk({transmitEmptyFlag, abortAcknowledgeBit}, 6'h12);
    eng(0);
    chk(txSel, 2'h2);
    clr(3'h0, 3'h4, 1'h0);
    chk({transmitEmptyFlag, abortRequestBit}, 6'h14);
    eng(1);
    chk({transmitEmptyFlag, abortAcknowledgeBit, txIrq}, 7'h65);
    @(posedge clk);
    txIe <= 3'h0;
    @(negedge clk);
    chk(txIrq, 1'h0);
    clr(3'h2, 3'h0, 1'h0);
    chk(abortAcknowledgeBit, 3'h0);
    $display("test transmit done");
    wrap_up();
  end
endmodule // tb_cmb_can_buffers
